// ===== design/ofp_map.svh
`ifndef OFP_MAP_SVH
`define OFP_MAP_SVH
`define OFP_ADDR_LOOP_COMP      8'h00
`define OFP_ADDR_FRAC_LOW       8'h05
`define OFP_ADDR_FRAC_MID       8'h06
`define OFP_ADDR_FRAC_HIGH      8'h07
`define OFP_ADDR_MULT_MIXED     8'h08
`define OFP_ADDR_MULT_COMMIT    8'h09
`define OFP_ADDR_VCO_DIV_LOW    8'h0a
`define OFP_ADDR_DIV_UPPER      8'h0b
`define OFP_ADDR_DISABLED_LEVEL 8'h0e
`define OFP_ADDR_PROD_FLOOR     8'h30
`define OFP_ADDR_PROD_CEIL      8'h31
`define OFP_ADDR_OUT_CTRL       8'h84
`define OFP_BIT_DRIVE_ENABLE    2
`define OFP_BIT_CAL_TRIGGER     0
`define OFP_RST_DRIVE_ENABLE    1'b1
`define OFP_RST_LOOP_COMP       8'h22
`define OFP_RST_FRAC            29'h0000000
`define OFP_RST_INT             9'h041
`define OFP_RST_VCO_DIV         10'h00a
`define OFP_RST_OUT_DIV         3'h0
`define OFP_RST_LEVEL           2'h0
`define OFP_PROD_FLOOR          8'h14
`define OFP_PROD_CEIL           8'hfa
`define OFP_CLK_PERIOD_NS       10
`define OFP_CAL_TIME_US         10000
`define OFP_CAL_CYCLES          ((`OFP_CAL_TIME_US * 1000) / `OFP_CLK_PERIOD_NS)
`define OFP_SETTLE_TIME_US      100
`define OFP_SETTLE_CYCLES       ((`OFP_SETTLE_TIME_US * 1000) / `OFP_CLK_PERIOD_NS)
`endif

// ===== design/ofp_pkg.sv
package ofp_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ofp_reg_req_s;
  typedef struct packed {
    logic [8:0]  mult_int;
    logic [28:0] mult_frac;
  } ofp_mult_s;
  typedef enum logic [1:0] {
    OFP_LVL_HIZ  = 2'b00,
    OFP_LVL_HIGH = 2'b01,
    OFP_LVL_LOW  = 2'b10,
    OFP_LVL_RSVD = 2'b11
  } ofp_level_e;
  typedef enum logic [1:0] {
    OFP_IDLE   = 2'b00,
    OFP_CAL    = 2'b01,
    OFP_SETTLE = 2'b10
  } ofp_state_e;
endpackage : ofp_pkg

// ===== design/ofp_freq_prog.sv
// Behaviour
// - New multiplier applied only on upper integer byte write; write it last.
// - Writing one to calibrate trigger starts calibration; bit reads zero.
// - No automatic large-change detection; host must trigger calibration.
// - Calibration and settling complete within 10 ms.
// - Output forced disabled when divider product outside floor/ceiling.
// - Small changes update only the multiplier; dividers unchanged.
// - Fraction LSB weight about 0.026 ppb near 71, doubling per bit.
// - Output divider code zero bypasses the final divider.
// - Output divider codes 000..101 map to ratios 1..32; others reserved.
// - Disabled level: 00 high impedance, 10 low, 01 high, 11 reserved.
// - Small-change multiplier updates settle within 100 us, output continuous.
// - Upper integer bits in commit byte 5:0; low three in mixed byte 7:5.
`timescale 1ns/1ps
`include "ofp_map.svh"
module ofp_freq_prog (
  input  wire logic                 clock_in,
  input  wire logic                 srst_in,
  input  wire ofp_pkg::ofp_reg_req_s req_in,
  output logic [7:0]                rdata_out,
  output ofp_pkg::ofp_mult_s        mult_out,
  output logic [9:0]                vco_divider_out,
  output logic [5:0]                output_ratio_out,
  output logic [3:0]                loop_comp_a_out,
  output logic [3:0]                loop_comp_b_out,
  output logic                      cal_busy_out,
  output logic                      settling_out,
  output logic                      drive_active_out,
  output logic                      level_out,
  output logic                      level_oe_out
);
  logic [7:0]         loop_comp_q;
  logic [28:0]        frac_shadow_q;
  logic [2:0]         int_low_shadow_q;
  logic [5:0]         int_high_q;
  logic [9:0]         vco_div_q;
  logic [2:0]         out_div_q;
  logic [1:0]         level_sel_q;
  logic               drive_en_q;
  ofp_pkg::ofp_state_e state_q;
  logic [23:0]        count_q;
  logic [15:0]        product_d;
  logic               product_ok_d;
  logic [5:0]         ratio_d;
  logic               cal_req_d;
  logic               wr_commit_d;

  assign cal_req_d   = req_in.wr && req_in.addr == `OFP_ADDR_OUT_CTRL
                       && req_in.wdata[`OFP_BIT_CAL_TRIGGER];
  assign wr_commit_d = req_in.wr && req_in.addr == `OFP_ADDR_MULT_COMMIT;

  // Ratio decode; reserved codes give zero so the product check disables output
  always_comb begin
    case (out_div_q)
      3'h0:    ratio_d = 6'h01;
      3'h1:    ratio_d = 6'h02;
      3'h2:    ratio_d = 6'h04;
      3'h3:    ratio_d = 6'h08;
      3'h4:    ratio_d = 6'h10;
      3'h5:    ratio_d = 6'h20;
      default: ratio_d = 6'h00;
    endcase
  end

  assign product_d    = {6'h00, vco_div_q} * {10'h000, ratio_d};
  assign product_ok_d = product_d >= 16'(`OFP_PROD_FLOOR)
                        && product_d <= 16'(`OFP_PROD_CEIL);

  // Register writes; reserved bits are not stored
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      loop_comp_q      <= `OFP_RST_LOOP_COMP;
      frac_shadow_q    <= `OFP_RST_FRAC;
      int_low_shadow_q <= 3'(`OFP_RST_INT & 9'h007);
      int_high_q       <= 6'(`OFP_RST_INT >> 3);
      vco_div_q        <= `OFP_RST_VCO_DIV;
      out_div_q        <= `OFP_RST_OUT_DIV;
      level_sel_q      <= `OFP_RST_LEVEL;
      drive_en_q       <= `OFP_RST_DRIVE_ENABLE;
    end else if (req_in.wr) begin
      case (req_in.addr)
        `OFP_ADDR_LOOP_COMP:   loop_comp_q <= req_in.wdata;
        `OFP_ADDR_FRAC_LOW:    frac_shadow_q[7:0] <= req_in.wdata;
        `OFP_ADDR_FRAC_MID:    frac_shadow_q[15:8] <= req_in.wdata;
        `OFP_ADDR_FRAC_HIGH:   frac_shadow_q[23:16] <= req_in.wdata;
        `OFP_ADDR_MULT_MIXED: begin
          int_low_shadow_q      <= req_in.wdata[7:5];
          frac_shadow_q[28:24]  <= req_in.wdata[4:0];
        end
        `OFP_ADDR_MULT_COMMIT: int_high_q <= req_in.wdata[5:0];
        `OFP_ADDR_VCO_DIV_LOW: vco_div_q[7:0] <= req_in.wdata;
        `OFP_ADDR_DIV_UPPER: begin
          out_div_q       <= req_in.wdata[6:4];
          vco_div_q[9:8]  <= req_in.wdata[1:0];
        end
        `OFP_ADDR_DISABLED_LEVEL: level_sel_q <= req_in.wdata[5:4];
        `OFP_ADDR_OUT_CTRL:  drive_en_q <= req_in.wdata[`OFP_BIT_DRIVE_ENABLE];
        default: ;
      endcase
    end
  end

  // Active multiplier moves only on the commit byte, all bits at once
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      mult_out.mult_int  <= `OFP_RST_INT;
      mult_out.mult_frac <= `OFP_RST_FRAC;
    end else if (wr_commit_d) begin
      mult_out.mult_int  <= {req_in.wdata[5:0], int_low_shadow_q};
      mult_out.mult_frac <= frac_shadow_q;
    end
  end

  // Divider and loop outputs follow their registers one clock later
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      vco_divider_out  <= `OFP_RST_VCO_DIV;
      output_ratio_out <= 6'h01;
      loop_comp_a_out  <= 4'(`OFP_RST_LOOP_COMP >> 4);
      loop_comp_b_out  <= 4'(`OFP_RST_LOOP_COMP & 8'h0f);
    end else begin
      vco_divider_out  <= vco_div_q;
      output_ratio_out <= ratio_d;
      loop_comp_a_out  <= loop_comp_q[7:4];
      loop_comp_b_out  <= loop_comp_q[3:0];
    end
  end

  // Calibration and small-change settle timing; a commit during calibration
  // is absorbed by the calibration wait rather than restarting it
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q      <= ofp_pkg::OFP_IDLE;
      count_q      <= 24'h000000;
      cal_busy_out <= 1'b0;
    end else begin
      case (state_q)
        ofp_pkg::OFP_IDLE: begin
          if (cal_req_d) begin
            state_q      <= ofp_pkg::OFP_CAL;
            count_q      <= 24'(`OFP_CAL_CYCLES - 1);
            cal_busy_out <= 1'b1;
          end else if (wr_commit_d) begin
            state_q <= ofp_pkg::OFP_SETTLE;
            count_q <= 24'(`OFP_SETTLE_CYCLES - 1);
          end
        end
        ofp_pkg::OFP_CAL: begin
          if (count_q == 24'h000000) begin
            state_q      <= ofp_pkg::OFP_IDLE;
            cal_busy_out <= 1'b0;
          end else begin
            count_q <= count_q - 24'h000001;
          end
        end
        ofp_pkg::OFP_SETTLE: begin
          if (cal_req_d) begin
            cal_busy_out <= 1'b1;
            state_q <= ofp_pkg::OFP_CAL;
            count_q <= 24'(`OFP_CAL_CYCLES - 1);
          end else if (wr_commit_d) begin
            count_q <= 24'(`OFP_SETTLE_CYCLES - 1);
          end else if (count_q == 24'h000000) begin
            state_q <= ofp_pkg::OFP_IDLE;
          end else begin
            count_q <= count_q - 24'h000001;
          end
        end
        default: begin
          state_q      <= ofp_pkg::OFP_IDLE;
          cal_busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Busy is its own flop, set with the state, so the output needs no decode

  // Output stage: driven only when enabled and product legal; calibration does not gate it
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      drive_active_out <= 1'b0;
      level_out        <= 1'b0;
      level_oe_out     <= 1'b0;
      settling_out     <= 1'b0;
    end else begin
      drive_active_out <= drive_en_q && product_ok_d;
      level_out        <= level_sel_q == ofp_pkg::OFP_LVL_HIGH;
      level_oe_out     <= !(drive_en_q && product_ok_d)
                          && (level_sel_q == ofp_pkg::OFP_LVL_HIGH
                              || level_sel_q == ofp_pkg::OFP_LVL_LOW);
      settling_out     <= state_q == ofp_pkg::OFP_SETTLE;
    end
  end

  // Read data; trigger bit always reads zero
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else if (req_in.rd) begin
      case (req_in.addr)
        `OFP_ADDR_LOOP_COMP:      rdata_out <= loop_comp_q;
        `OFP_ADDR_FRAC_LOW:       rdata_out <= frac_shadow_q[7:0];
        `OFP_ADDR_FRAC_MID:       rdata_out <= frac_shadow_q[15:8];
        `OFP_ADDR_FRAC_HIGH:      rdata_out <= frac_shadow_q[23:16];
        `OFP_ADDR_MULT_MIXED:     rdata_out <= {int_low_shadow_q, frac_shadow_q[28:24]};
        `OFP_ADDR_MULT_COMMIT:    rdata_out <= {2'h0, int_high_q};
        `OFP_ADDR_VCO_DIV_LOW:    rdata_out <= vco_div_q[7:0];
        `OFP_ADDR_DIV_UPPER:      rdata_out <= {1'b0, out_div_q, 2'h0, vco_div_q[9:8]};
        `OFP_ADDR_DISABLED_LEVEL: rdata_out <= {2'h0, level_sel_q, 4'h0};
        `OFP_ADDR_PROD_FLOOR:     rdata_out <= `OFP_PROD_FLOOR;
        `OFP_ADDR_PROD_CEIL:      rdata_out <= `OFP_PROD_CEIL;
        `OFP_ADDR_OUT_CTRL:       rdata_out <= {5'h00, drive_en_q, 2'h0};
        default:                  rdata_out <= 8'h00;
      endcase
    end
  end
endmodule : ofp_freq_prog

// ===== verification/ofp_checker.sv
`timescale 1ns/1ps
module ofp_checker (
  input wire logic                  clock_in,
  input wire logic                  srst_in,
  input wire ofp_pkg::ofp_reg_req_s req_in,
  input wire logic [7:0]            rdata_out,
  input wire ofp_pkg::ofp_mult_s    mult_out,
  input wire logic [9:0]            vco_divider_out,
  input wire logic [5:0]            output_ratio_out,
  input wire logic                  cal_busy_out,
  input wire logic                  settling_out,
  input wire logic                  drive_active_out,
  input wire logic                  level_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  wire logic        cmt_w  = req_in.wr && req_in.addr == 8'h09;
  wire logic        trg_w  = req_in.wr && req_in.addr == 8'h84 && req_in.wdata[0];
  wire logic [15:0] prod_w = {6'h00, vco_divider_out} * {10'h000, output_ratio_out};
  commit_only_a: assert property (!$stable(mult_out) |-> $past(cmt_w))
    else $error("multiplier moved without commit");
  commit_map_a: assert property (cmt_w |=>
    mult_out.mult_int[8:3] == $past(req_in.wdata[5:0]))
    else $error("commit byte misplaced");
  // A commit while calibrating is absorbed by the calibration wait
  settle_go_a: assert property (cmt_w && !cal_busy_out |=> ##1 settling_out)
    else $error("settle timer not started");
  cal_go_a: assert property (trg_w && !cal_busy_out |=> cal_busy_out)
    else $error("calibration not started");
  cal_cause_a: assert property ($rose(cal_busy_out) |-> $past(trg_w))
    else $error("calibration without trigger");
  trig_zero_a: assert property (req_in.rd && req_in.addr == 8'h84 |=> !rdata_out[0])
    else $error("trigger bit read as one");
  ratio_code_a: assert property ($onehot0(output_ratio_out))
    else $error("ratio not a power of two");
  prod_gate_a: assert property (output_ratio_out == 6'h00 [*2] |-> !drive_active_out)
    else $error("driver on with illegal product");
  prod_band_a: assert property (drive_active_out |-> prod_w inside {[16'h0014:16'h00fa]})
    else $error("driver on outside product band");
  level_off_a: assert property (drive_active_out [*3] |-> !level_oe_out)
    else $error("level driven while enabled");
  cover property (cmt_w);
  cover property ($rose(cal_busy_out));
  cover property ($fell(settling_out));
endmodule : ofp_checker

// ===== verification/ofp_host_model.sv
`timescale 1ns/1ps
module ofp_host_model (
  input  wire logic             clock_in,
  input  wire logic [7:0]       rdata_in,
  output ofp_pkg::ofp_reg_req_s req_out
);
  initial req_out = '0;
  // Released fields show the inverse so a stale address never passes as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    req_out = '{1'b1, 1'b0, a, d};
    @(negedge clock_in);
    req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    req_out = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock_in);
    req_out = '{1'b0, 1'b0, ~a, 8'hff};
    d = rdata_in;
  endtask : rd
endmodule : ofp_host_model

// ===== verification/ofp_freq_prog_tb.sv
`timescale 1ns/1ps
module ofp_freq_prog_tb;
  logic                  clock_in, srst_in, busy, settling, drive, lvl, lvl_oe;
  ofp_pkg::ofp_reg_req_s req;
  ofp_pkg::ofp_mult_s    mult;
  logic [7:0]            rdata, rv;
  logic [9:0]            vco;
  logic [5:0]            ratio, er;
  logic [3:0]            la, lb;
  int                    miscompares, checks_done, n;
  ofp_freq_prog DUT (.clock_in, .srst_in, .req_in(req), .rdata_out(rdata), .mult_out(mult),
    .vco_divider_out(vco), .output_ratio_out(ratio), .loop_comp_a_out(la),
    .loop_comp_b_out(lb), .cal_busy_out(busy), .settling_out(settling),
    .drive_active_out(drive), .level_out(lvl), .level_oe_out(lvl_oe));
  ofp_host_model host (.clock_in, .rdata_in(rdata), .req_out(req));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk(rv, e);
  endtask : rchk
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    srst_in = 1'b1;
    repeat (16) @(negedge clock_in);
    srst_in = 1'b0;
    chk({la, lb, ratio, mult}, {8'h22, 6'h01, 9'h041, 29'h0});
    rchk(8'h31, 8'hfa);
    // Reset dividers give a product of 10, below the floor of 20
    chk(drive, 1'b0);
    host.wr(8'h30, 8'h00);
    rchk(8'h30, 8'h14);
    rchk(8'h40, 8'h00);
    rchk(8'h84, 8'h04);
    $display("end reset test");
    host.wr(8'h05, 8'h85);
    host.wr(8'h06, 8'hcf);
    host.wr(8'h07, 8'h1d);
    host.wr(8'h08, 8'h47);
    chk(mult, {9'h041, 29'h0});
    host.wr(8'h09, 8'h09);
    chk(mult, {9'h04a, 29'h071dcf85});
    rchk(8'h08, 8'h47);
    n = 0;
    while (settling === 1'b1 && n < 10100) begin
      @(negedge clock_in);
      n++;
    end
    chk(n > 9900 && n < 10100, 1'b1);
    if (n >= 10100) results();
    $display("end small change test");
    host.wr(8'h0a, 8'h2a);
    // Divider 42 makes codes 0 to 2 legal, codes 3 to 5 exceed the ceiling, reserved 6 and 7 give zero
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h0b, {1'b0, c[2:0], 4'h0});
      repeat (3) @(negedge clock_in);
      er = (c < 6) ? (6'h01 << c) : 6'h00;
      chk(ratio, er);
      chk(drive, er != 0 && er * 42 >= 20 && er * 42 <= 250);
    end
    chk(vco, 10'h02a);
    host.wr(8'h0b, 8'h00);
    $display("end divider test");
    // Large change to the 54 MHz table entry: ratio 1, divider 40, loop 2/3
    host.wr(8'h84, 8'h00);
    host.wr(8'h00, 8'h23);
    host.wr(8'h05, 8'hee);
    host.wr(8'h06, 8'hd0);
    host.wr(8'h07, 8'h59);
    host.wr(8'h08, 8'h71);
    host.wr(8'h09, 8'h08);
    host.wr(8'h0a, 8'h28);
    host.wr(8'h0b, 8'h00);
    host.wr(8'h84, 8'h01);
    @(negedge clock_in);
    chk({busy, drive}, 2'b10);
    chk({la, lb, ratio, vco, mult}, {8'h23, 6'h01, 10'h028, 9'h043, 29'h1159d0ee});
    rchk(8'h84, 8'h00);
    rchk(8'h0a, 8'h28);
    $display("end calibration test");
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h0e, {2'b00, c[1:0], 4'h0});
      repeat (2) @(negedge clock_in);
      chk({lvl_oe, lvl}, {c == 1 || c == 2, c == 1});
    end
    // Drive high while disabled, so enabling must visibly release the level
    host.wr(8'h0e, 8'h10);
    host.wr(8'h84, 8'h05);
    repeat (2) @(negedge clock_in);
    chk({busy, drive, lvl_oe}, 3'b110);
    $display("end level test");
    results();
  end
endmodule : ofp_freq_prog_tb
bind ofp_freq_prog ofp_checker u_chk (.clock_in, .srst_in, .req_in, .rdata_out, .mult_out,
  .vco_divider_out, .output_ratio_out, .cal_busy_out, .settling_out, .drive_active_out,
  .level_oe_out);
